// [sysopt_pkg.sv]
//==============================================================
//==============================================================
package sysopt_pkg;
   // =============================================================
   // register selects on the local register port
   localparam logic [1:0] FORCE_RESET_OFS = 2'h0; // debug force-reset register
   localparam logic [1:0] OPTIONS_ONE_OFS = 2'h1; // options register one
   localparam logic [1:0] OPTIONS_TWO_OFS = 2'h2; // options register two
   // =============================================================
   // field positions, options register one
   localparam int WD_ENABLE_BIT = 7; // watchdog enable
   localparam int WD_CLK_SEL_BIT = 6; // watchdog clock select
   localparam int STOP_PERMIT_BIT = 5; // stop permit
   localparam int DBG_PIN_BIT = 1; // debug pin enable
   // field positions, options register two
   localparam int TEMP_WAKE_BIT = 7; // temperature restart wake enable
   localparam int WD_TIMEOUT_HI = 6; // watchdog time-out field top
   localparam int WD_TIMEOUT_LO = 4; // watchdog time-out field bottom
   localparam int CH0_SRC_BIT = 3; // timer ch0 clock source
   localparam int EXT_DIV_BIT = 2; // external timer clock divider
   localparam int BUS_DIV_HI = 1; // bus clock divider top
   localparam int BUS_DIV_LO = 0; // bus clock divider bottom
   // force-reset bit position
   localparam int FORCE_RESET_BIT = 0;
   // =============================================================
   // reset values and implemented-bit masks
   localparam logic [7:0] OPTIONS_ONE_RST = 8'h82; // watchdog on, debug pin
   localparam logic [7:0] OPTIONS_ONE_MASK = 8'hE2; // unimplemented bits read zero
   localparam logic [7:0] OPTIONS_TWO_RST = 8'h00;
   localparam logic [7:0] OPTIONS_TWO_MASK = 8'hFF;
   localparam logic [7:0] FORCE_RESET_READ = 8'h00; // force register read value
   // =============================================================
   // counts
   localparam logic [2:0] EXT_DIV_LAST = 3'h7; // divide by eight: 0..7
endpackage : sysopt_pkg

// [pin_sync.sv]
`timescale 1ns/1ps
// =============================================================
// three-stage pin synchroniser
// =============================================================
module pin_sync (
   input wire logic clk_in, // bus clock
   input wire logic rst_n_in, // async reset, active low
   input wire logic pin_in, // asynchronous pin level
   output logic level_out // filtered level
);
   logic meta_reg; // first stage, read only by second
   logic mid_reg; // second stage
   logic late_reg; // third stage

   // =============================================================
   // shift chain; a glitch shorter than a cycle is dropped
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_reg <= 1'b0;
         mid_reg <= 1'b0;
         late_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= pin_in;
         mid_reg <= meta_reg;
         late_reg <= mid_reg;
      end
   end

   // change counts once second and third stages agree
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         level_out <= 1'b0;
      else if (mid_reg == late_reg)
         level_out <= late_reg;
   end
endmodule : pin_sync

// [ext_clock_divider.sv]
`timescale 1ns/1ps
// =============================================================
// external timer clock edge divider, by one or by eight
// =============================================================
module ext_clock_divider (
   input wire logic clk_in, // bus clock
   input wire logic rst_n_in, // async reset, active low
   input wire logic level_in, // synchronised external clock
   input wire logic div8_in, // one selects divide by eight
   output logic tick_out // one-cycle pulse per divided edge
);
   logic last_reg; // previous level for edge detect
   logic [2:0] count_reg; // rising edges seen
   logic rise; // rising edge this cycle

   assign rise = level_in & ~last_reg;

   // =============================================================
   // edge history
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         last_reg <= 1'b0;
      else
         last_reg <= level_in;
   end

   // edge counter; held at zero in divide-by-one
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         count_reg <= 3'h0;
      else if (!div8_in)
         count_reg <= 3'h0;
      else if (rise)
         count_reg <= count_reg + 3'h1;
   end

   // tick on every rising edge, or on every eighth
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         tick_out <= 1'b0;
      else
         tick_out <= rise & (!div8_in | (count_reg == sysopt_pkg::EXT_DIV_LAST));
   end
endmodule : ext_clock_divider

// [system_option_registers.sv]
`timescale 1ns/1ps
// =============================================================
// system option and debug force-reset register bank
// =============================================================
module system_option_registers (
   input wire logic clk_in, // bus clock
   input wire logic rst_n_in, // any mcu reset, active low
   // user program register port
   input wire logic user_wr_in, // write strobe
   input wire logic user_rd_in, // read strobe
   input wire logic [1:0] user_sel_in, // register select
   input wire logic [7:0] user_wdata_in, // write data
   output logic [7:0] user_rdata_out, // read data
   output logic user_rvalid_out, // read data valid pulse
   // background debug command port
   input wire logic dbg_wr_in, // debug write strobe
   input wire logic [1:0] dbg_sel_in, // debug register select
   input wire logic [7:0] dbg_wdata_in, // debug write data
   // system reset request
   output logic force_reset_out, // to reset controller
   // stop handling
   input wire logic stop_exec_in, // stop instruction pulse
   output logic stop_enter_out, // stop mode entry pulse
   output logic illegal_stop_reset_out, // illegal-opcode reset request
   // option outputs
   output logic watchdog_enable_out, // watchdog enabled
   output logic watchdog_clock_select_out, // 0 1-kHz, 1 bus clock
   output logic [2:0] watchdog_timeout_select_out, // time-out select
   output logic temp_restart_wake_enable_out, // temperature restart wake
   output logic [1:0] bus_clock_divider_out, // hfo divide select
   // shared debug pin
   input wire logic port_c_data_in, // general-purpose output value
   output logic debug_pin_function_out, // 1 debug pin, 0 port bit
   output logic port_c_bit_zero_out, // port bit drive value
   output logic port_c_bit_zero_oe_out, // port bit drive enable
   // timer clocks
   input wire logic port_a_bit_two_in, // timer ch0 pin input
   input wire logic low_frequency_oscillator_in, // low frequency oscillator
   input wire logic ext_timer_clock_in, // external timer clock pin
   output logic timer_ch0_clock_input_out, // selected ch0 clock level
   output logic ext_timer_tick_out // divided external clock pulse
);
   // =============================================================
   // storage
   logic [7:0] options_reg_one; // options one, implemented bits only
   logic [7:0] options_reg_two; // options two
   logic lock_one_reg; // options one already written
   logic lock_two_reg; // options two already written
   logic pa2_level; // synchronised port a bit two
   logic lfo_level; // synchronised oscillator
   logic ext_level; // synchronised external clock
   logic wr_any; // write from either source
   logic [1:0] wr_sel; // merged write select
   logic [7:0] wr_data; // merged write data
   logic [7:0] rd_next; // read mux

   // =============================================================
   // write merge; debug command wins a same-cycle collision
   always_comb
   begin
      wr_any = dbg_wr_in | user_wr_in;
      if (dbg_wr_in)
      begin
         wr_sel = dbg_sel_in;
         wr_data = dbg_wdata_in;
      end
      else
      begin
         wr_sel = user_sel_in;
         wr_data = user_wdata_in;
      end
   end

   // =============================================================
   // options register one, write-once
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         options_reg_one <= sysopt_pkg::OPTIONS_ONE_RST;
      else if (wr_any && wr_sel == sysopt_pkg::OPTIONS_ONE_OFS && !lock_one_reg)
         options_reg_one <= wr_data & sysopt_pkg::OPTIONS_ONE_MASK;
   end

   // lock for options one; cleared only by reset
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         lock_one_reg <= 1'b0;
      else if (wr_any && wr_sel == sysopt_pkg::OPTIONS_ONE_OFS)
         lock_one_reg <= 1'b1;
   end

   // options register two, write-once
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         options_reg_two <= sysopt_pkg::OPTIONS_TWO_RST;
      else if (wr_any && wr_sel == sysopt_pkg::OPTIONS_TWO_OFS && !lock_two_reg)
         options_reg_two <= wr_data & sysopt_pkg::OPTIONS_TWO_MASK;
   end

   // lock for options two
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         lock_two_reg <= 1'b0;
      else if (wr_any && wr_sel == sysopt_pkg::OPTIONS_TWO_OFS)
         lock_two_reg <= 1'b1;
   end

   // =============================================================
   // force reset: debug path only, held until the reset arrives
   // so the reset controller cannot miss a one-cycle request
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         force_reset_out <= 1'b0;
      else if (dbg_wr_in && dbg_sel_in == sysopt_pkg::FORCE_RESET_OFS
               && dbg_wdata_in[sysopt_pkg::FORCE_RESET_BIT])
         force_reset_out <= 1'b1;
   end

   // =============================================================
   // read port; force register reads zero whatever was written
   always_comb
   begin
      case (user_sel_in)
         sysopt_pkg::FORCE_RESET_OFS: rd_next = sysopt_pkg::FORCE_RESET_READ;
         sysopt_pkg::OPTIONS_ONE_OFS: rd_next = options_reg_one;
         sysopt_pkg::OPTIONS_TWO_OFS: rd_next = options_reg_two;
         default: rd_next = 8'h00; // unmapped select
      endcase
   end

   // read data and valid, one cycle after the strobe
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         user_rdata_out <= 8'h00;
         user_rvalid_out <= 1'b0;
      end
      else
      begin
         user_rvalid_out <= user_rd_in;
         if (user_rd_in)
            user_rdata_out <= rd_next;
      end
   end

   // =============================================================
   // stop instruction: enter stop if permitted, else reset request
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         stop_enter_out <= 1'b0;
         illegal_stop_reset_out <= 1'b0;
      end
      else
      begin
         stop_enter_out <= stop_exec_in & options_reg_one[sysopt_pkg::STOP_PERMIT_BIT];
         if (stop_exec_in && !options_reg_one[sysopt_pkg::STOP_PERMIT_BIT])
            illegal_stop_reset_out <= 1'b1;
      end
   end

   // =============================================================
   // option fields out through flops
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         // mirror the register reset values so outputs differ from the registers only in the cycle after a write
         watchdog_enable_out <= sysopt_pkg::OPTIONS_ONE_RST[sysopt_pkg::WD_ENABLE_BIT];
         watchdog_clock_select_out <= sysopt_pkg::OPTIONS_ONE_RST[sysopt_pkg::WD_CLK_SEL_BIT];
         watchdog_timeout_select_out <=
            sysopt_pkg::OPTIONS_TWO_RST[sysopt_pkg::WD_TIMEOUT_HI:sysopt_pkg::WD_TIMEOUT_LO];
         temp_restart_wake_enable_out <= sysopt_pkg::OPTIONS_TWO_RST[sysopt_pkg::TEMP_WAKE_BIT];
         bus_clock_divider_out <=
            sysopt_pkg::OPTIONS_TWO_RST[sysopt_pkg::BUS_DIV_HI:sysopt_pkg::BUS_DIV_LO];
      end
      else
      begin
         watchdog_enable_out <= options_reg_one[sysopt_pkg::WD_ENABLE_BIT];
         watchdog_clock_select_out <= options_reg_one[sysopt_pkg::WD_CLK_SEL_BIT];
         watchdog_timeout_select_out <=
            options_reg_two[sysopt_pkg::WD_TIMEOUT_HI:sysopt_pkg::WD_TIMEOUT_LO];
         temp_restart_wake_enable_out <= options_reg_two[sysopt_pkg::TEMP_WAKE_BIT];
         bus_clock_divider_out <=
            options_reg_two[sysopt_pkg::BUS_DIV_HI:sysopt_pkg::BUS_DIV_LO];
      end
   end

   // shared pin: port bit drives only when debug function is off
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         debug_pin_function_out <= sysopt_pkg::OPTIONS_ONE_RST[sysopt_pkg::DBG_PIN_BIT];
         port_c_bit_zero_out <= 1'b0;
         port_c_bit_zero_oe_out <= ~sysopt_pkg::OPTIONS_ONE_RST[sysopt_pkg::DBG_PIN_BIT];
      end
      else
      begin
         debug_pin_function_out <= options_reg_one[sysopt_pkg::DBG_PIN_BIT];
         port_c_bit_zero_out <= port_c_data_in;
         port_c_bit_zero_oe_out <= ~options_reg_one[sysopt_pkg::DBG_PIN_BIT];
      end
   end

   // =============================================================
   // pin synchronisers
   pin_sync pa2_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .pin_in(port_a_bit_two_in),
      .level_out(pa2_level)
   );
   pin_sync lfo_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .pin_in(low_frequency_oscillator_in),
      .level_out(lfo_level)
   );
   pin_sync ext_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .pin_in(ext_timer_clock_in),
      .level_out(ext_level)
   );

   // timer ch0 clock source mux
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         timer_ch0_clock_input_out <= 1'b0;
      else if (options_reg_two[sysopt_pkg::CH0_SRC_BIT])
         timer_ch0_clock_input_out <= lfo_level;
      else
         timer_ch0_clock_input_out <= pa2_level;
   end

   // external timer clock divider
   ext_clock_divider ext_div (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .level_in(ext_level),
      .div8_in(options_reg_two[sysopt_pkg::EXT_DIV_BIT]),
      .tick_out(ext_timer_tick_out)
   );

   // =============================================================
   // checks
   user_force_ignored_a:
      assert property (@(posedge clk_in) disable iff (!rst_n_in)
         (!force_reset_out && !dbg_wr_in) |=> !force_reset_out)
      else $error("force reset set without debug write");

   force_reads_zero_a:
      assert property (@(posedge clk_in) disable iff (!rst_n_in)
         (user_rd_in && user_sel_in == sysopt_pkg::FORCE_RESET_OFS)
         |=> user_rvalid_out && user_rdata_out == 8'h00)
      else $error("force register read not zero");

   debug_force_reset_a:
      assert property (@(posedge clk_in) disable iff (!rst_n_in)
         (dbg_wr_in && dbg_sel_in == sysopt_pkg::FORCE_RESET_OFS && dbg_wdata_in[0])
         |=> force_reset_out ##1 force_reset_out)
      else $error("debug force reset not raised");

   options_one_once_a:
      assert property (@(posedge clk_in) disable iff (!rst_n_in)
         lock_one_reg |=> $stable(options_reg_one))
      else $error("options one changed after lock");

   options_two_once_a:
      assert property (@(posedge clk_in) disable iff (!rst_n_in)
         lock_two_reg |=> $stable(options_reg_two))
      else $error("options two changed after lock");

   unlocked_defaults_a:
      assert property (@(posedge clk_in) disable iff (!rst_n_in)
         !lock_one_reg |-> options_reg_one == sysopt_pkg::OPTIONS_ONE_RST)
      else $error("options one left defaults before write");

   stop_denied_a:
      assert property (@(posedge clk_in) disable iff (!rst_n_in)
         (stop_exec_in && !options_reg_one[5]) |=> illegal_stop_reset_out && !stop_enter_out)
      else $error("stop not turned into reset");

   pin_function_a:
      assert property (@(posedge clk_in) disable iff (!rst_n_in)
         ##1 (debug_pin_function_out == $past(options_reg_one[1]))
         && (port_c_bit_zero_oe_out != debug_pin_function_out))
      else $error("pin function and drive disagree");

   ch0_source_a:
      assert property (@(posedge clk_in) disable iff (!rst_n_in)
         ##1 timer_ch0_clock_input_out == ($past(options_reg_two[3]) ? $past(lfo_level)
                                                                     : $past(pa2_level)))
      else $error("timer ch0 source wrong");

   lock_on_write_a:
      assert property (@(posedge clk_in) disable iff (!rst_n_in)
         (wr_any && wr_sel == sysopt_pkg::OPTIONS_TWO_OFS) |=> lock_two_reg [*2])
      else $error("options two lock not set");
endmodule : system_option_registers

// [debug_host_model.sv]
`timescale 1ns/1ps
// ==============================================================
// background debug host: issues byte writes on the debug port
// ==============================================================
module debug_host_model (
   input wire logic clk_in, // bus clock
   output logic dbg_wr_out, // debug write strobe
   output logic [1:0] dbg_sel_out, // register select
   output logic [7:0] dbg_wdata_out // write data
);
   // idle state, strobe low
   initial
   begin
      dbg_wr_out = 1'b0;
      dbg_sel_out = 2'h3;
      dbg_wdata_out = 8'h00;
   end
   // one write command, a single strobed cycle; a one in bit 0 of the
   // force register asks for a full reset
   task automatic write_byte(input logic [1:0] sel, input logic [7:0] data);
      @(negedge clk_in);
      dbg_wr_out = 1'b1;
      dbg_sel_out = sel;
      dbg_wdata_out = data;
      @(negedge clk_in);
      dbg_wr_out = 1'b0;
      // fields scrambled once released, so stale data never looks held
      dbg_sel_out = ~sel;
      dbg_wdata_out = ~data;
   endtask : write_byte
endmodule : debug_host_model

// [tb_system_option_registers.sv]
`timescale 1ns/1ps
// ==============================================================
// bench for the option register bank
// ==============================================================
module tb_system_option_registers;
   logic clk_in, rst_n_in, user_wr_in, user_rd_in, stop_exec_in, port_c_data_in;
   logic port_a_bit_two_in, low_frequency_oscillator_in, ext_timer_clock_in;
   logic [1:0] user_sel_in, dbg_sel_in, bus_clock_divider_out;
   logic [7:0] user_wdata_in, dbg_wdata_in, user_rdata_out, rd;
   logic dbg_wr_in, user_rvalid_out, force_reset_out, stop_enter_out, illegal_stop_reset_out;
   logic watchdog_enable_out, watchdog_clock_select_out, temp_restart_wake_enable_out;
   logic debug_pin_function_out, port_c_bit_zero_out, port_c_bit_zero_oe_out;
   logic timer_ch0_clock_input_out, ext_timer_tick_out;
   logic [2:0] watchdog_timeout_select_out;
   int mismatches, n_checks, cycles, ticks;
   // option two patterns: every bus divider code, both divider settings
   logic [7:0] two_vals [4] = '{8'h98, 8'h25, 8'hCE, 8'h77};

   system_option_registers u_system_option_registers (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .user_wr_in(user_wr_in), .user_rd_in(user_rd_in), .user_sel_in(user_sel_in),
      .user_wdata_in(user_wdata_in), .user_rdata_out(user_rdata_out),
      .user_rvalid_out(user_rvalid_out), .dbg_wr_in(dbg_wr_in), .dbg_sel_in(dbg_sel_in),
      .dbg_wdata_in(dbg_wdata_in), .force_reset_out(force_reset_out),
      .stop_exec_in(stop_exec_in), .stop_enter_out(stop_enter_out),
      .illegal_stop_reset_out(illegal_stop_reset_out),
      .watchdog_enable_out(watchdog_enable_out),
      .watchdog_clock_select_out(watchdog_clock_select_out),
      .watchdog_timeout_select_out(watchdog_timeout_select_out),
      .temp_restart_wake_enable_out(temp_restart_wake_enable_out),
      .bus_clock_divider_out(bus_clock_divider_out), .port_c_data_in(port_c_data_in),
      .debug_pin_function_out(debug_pin_function_out),
      .port_c_bit_zero_out(port_c_bit_zero_out),
      .port_c_bit_zero_oe_out(port_c_bit_zero_oe_out), .port_a_bit_two_in(port_a_bit_two_in),
      .low_frequency_oscillator_in(low_frequency_oscillator_in),
      .ext_timer_clock_in(ext_timer_clock_in),
      .timer_ch0_clock_input_out(timer_ch0_clock_input_out),
      .ext_timer_tick_out(ext_timer_tick_out));

   debug_host_model u_debug_host_model (.clk_in(clk_in), .dbg_wr_out(dbg_wr_in),
      .dbg_sel_out(dbg_sel_in), .dbg_wdata_out(dbg_wdata_in));

   // ==============================================================
   // clock, tick counter and hang guard
   // ==============================================================
   initial
   begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // counts divided external clock pulses
   always @(posedge clk_in)
   begin
      if (ext_timer_tick_out === 1'b1)
         ticks <= ticks + 1;
      cycles <= cycles + 1;
      // tests need about 1130 cycles
      if (cycles == 6000)
      begin
         mismatches++;
         complete_run();
      end
   end

   // ==============================================================
   // tasks
   // ==============================================================
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one strobed write cycle
   task automatic user_write(input logic [1:0] sel, input logic [7:0] data);
      @(negedge clk_in);
      user_wr_in = 1'b1;
      user_sel_in = sel;
      user_wdata_in = data;
      @(negedge clk_in);
      user_wr_in = 1'b0;
   endtask : user_write
   // read strobe, data and valid are looked at in the following cycle
   task automatic user_read(input logic [1:0] sel, output logic [7:0] data);
      @(negedge clk_in);
      user_rd_in = 1'b1;
      user_sel_in = sel;
      @(negedge clk_in);
      user_rd_in = 1'b0;
      check(8'(user_rvalid_out), 8'h01);
      data = user_rdata_out;
   endtask : user_read
   // stop instruction pulse; outcome looked at in the next cycle
   task automatic stop_pulse;
      @(negedge clk_in);
      stop_exec_in = 1'b1;
      @(negedge clk_in);
      stop_exec_in = 1'b0;
   endtask : stop_pulse
   // stands in for the reset controller
   task automatic do_reset;
      @(negedge clk_in);
      rst_n_in = 1'b0;
      repeat (3) @(negedge clk_in);
      rst_n_in = 1'b1;
   endtask : do_reset
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   // ==============================================================
   // test sequence
   // ==============================================================
   initial
   begin
      {mismatches, n_checks, cycles, ticks} = '0;
      {rst_n_in, user_wr_in, user_rd_in, stop_exec_in, port_c_data_in} = '0;
      {port_a_bit_two_in, ext_timer_clock_in, user_sel_in, user_wdata_in} = '0;
      low_frequency_oscillator_in = 1'b1;
      repeat (3) @(negedge clk_in);
      rst_n_in = 1'b1;
      // defaults after reset
      user_read(sysopt_pkg::FORCE_RESET_OFS, rd);
      check(rd, 8'h00);
      user_read(sysopt_pkg::OPTIONS_ONE_OFS, rd);
      check(rd, 8'h82);
      check(8'(watchdog_enable_out), 8'h01);
      check(8'(debug_pin_function_out), 8'h01);
      check(8'(port_c_bit_zero_oe_out), 8'h00);
      user_read(2'h3, rd);
      check(rd, 8'h00);
      $display("test defaults done");
      // user program cannot force a reset
      user_write(sysopt_pkg::FORCE_RESET_OFS, 8'hFF);
      @(negedge clk_in);
      check(8'(force_reset_out), 8'h00);
      user_read(sysopt_pkg::FORCE_RESET_OFS, rd);
      check(rd, 8'h00);
      // stop while stop is not permitted
      stop_pulse();
      check(8'(illegal_stop_reset_out), 8'h01);
      check(8'(stop_enter_out), 8'h00);
      do_reset();
      $display("test user force and stop done");
      // options one: first write taken, masked bit 0 dropped, later writes lost
      user_write(sysopt_pkg::OPTIONS_ONE_OFS, 8'h61);
      port_c_data_in = 1'b1;
      repeat (2) @(negedge clk_in);
      check(8'(watchdog_enable_out), 8'h00);
      check(8'(watchdog_clock_select_out), 8'h01);
      check(8'(debug_pin_function_out), 8'h00);
      check(8'(port_c_bit_zero_oe_out), 8'h01);
      check(8'(port_c_bit_zero_out), 8'h01);
      user_write(sysopt_pkg::OPTIONS_ONE_OFS, 8'h82);
      u_debug_host_model.write_byte(sysopt_pkg::OPTIONS_ONE_OFS, 8'h9E);
      user_read(sysopt_pkg::OPTIONS_ONE_OFS, rd);
      check(rd, 8'h60);
      stop_pulse();
      check(8'(stop_enter_out), 8'h01);
      check(8'(illegal_stop_reset_out), 8'h00);
      $display("test options one done");
      // debug host forces a reset; all options return to defaults
      u_debug_host_model.write_byte(sysopt_pkg::FORCE_RESET_OFS, 8'h01);
      check(8'(force_reset_out), 8'h01);
      do_reset();
      check(8'(force_reset_out), 8'h00);
      user_read(sysopt_pkg::OPTIONS_ONE_OFS, rd);
      check(rd, 8'h82);
      user_write(sysopt_pkg::OPTIONS_ONE_OFS, 8'h00);
      user_read(sysopt_pkg::OPTIONS_ONE_OFS, rd);
      check(rd, 8'h00);
      $display("test debug force done");
      // options two patterns, each after a fresh reset
      for (int i = 0; i < 4; i++)
      begin
         do_reset();
         // pin follows field bit 4 so the port a leg is seen at both levels, the oscillator leg high only
         port_a_bit_two_in = two_vals[i][4];
         user_write(sysopt_pkg::OPTIONS_ONE_OFS, 8'h82);
         user_write(sysopt_pkg::OPTIONS_TWO_OFS, two_vals[i]);
         user_write(sysopt_pkg::OPTIONS_TWO_OFS, ~two_vals[i]);
         // a first write equal to the defaults must still lock
         user_write(sysopt_pkg::OPTIONS_ONE_OFS, 8'h00);
         @(negedge clk_in);
         check(8'(watchdog_enable_out), 8'h01);
         check(8'(temp_restart_wake_enable_out), 8'(two_vals[i][7]));
         check(8'(watchdog_timeout_select_out), 8'(two_vals[i][6:4]));
         check(8'(bus_clock_divider_out), 8'(two_vals[i][1:0]));
         user_read(sysopt_pkg::OPTIONS_TWO_OFS, rd);
         check(rd, two_vals[i]);
         // sixteen slow external clock edges
         ticks = 0;
         for (int j = 0; j < 16; j++)
         begin
            ext_timer_clock_in = 1'b1;
            repeat (8) @(negedge clk_in);
            ext_timer_clock_in = 1'b0;
            repeat (8) @(negedge clk_in);
         end
         check(8'(ticks), two_vals[i][2] ? 8'h02 : 8'h10);
         // oscillator held high, pin follows bit 4 of the pattern
         check(8'(timer_ch0_clock_input_out), two_vals[i][3] ? 8'h01 : 8'(two_vals[i][4]));
         $display("test options two pattern %0d done", i);
      end
      complete_run();
   end
endmodule : tb_system_option_registers
